// ===== amr_consts.vh
// constants for the accumulator move and return decoder
`ifndef AMR_CONSTS_VH
`define AMR_CONSTS_VH

// instruction word, data and register address field widths
`define AMR_IW            14
`define AMR_DW            8
`define AMR_FW            7
// store accumulator: 00 0000 1fff ffff
`define AMR_STORE_MASK    14'h3f80
`define AMR_STORE_PAT     14'h0080
// load literal: 11 00xx kkkk kkkk
`define AMR_LDLIT_MASK    14'h3c00
`define AMR_LDLIT_PAT     14'h3000
// no operation: 00 0000 0xx0 0000
`define AMR_NOP_MASK      14'h3f9f
`define AMR_NOP_PAT       14'h0000
// return from interrupt: 00 0000 0000 1001
`define AMR_RETI_PAT      14'h0009
// legacy option load: 00 0000 0110 0010
`define AMR_OPTLD_PAT     14'h0062
// global enable bit position in irq control register
`define AMR_GIE_BIT       7
// cycles taken by return from interrupt
`define AMR_RETI_CYCLES   2
// reset values
`define AMR_ACC_RST       8'h00
`define AMR_OPT_RST       8'hff

`endif

// ===== amr_match.v
// instruction pattern matcher for the decoder group
`default_nettype none
`include "amr_consts.vh"

module amr_match (
    input  wire [13:0] instr_i,
    output wire        is_ldlit_o,
    output wire        is_store_o,
    output wire        is_nop_o,
    output wire        is_reti_o,
    output wire        is_optld_o
);

    // masked compares for ldlit, store and nop, don't-care bits cleared by the mask; exact compares for reti and optld
    assign is_ldlit_o = (instr_i & `AMR_LDLIT_MASK) == `AMR_LDLIT_PAT;
    assign is_store_o = (instr_i & `AMR_STORE_MASK) == `AMR_STORE_PAT;
    assign is_nop_o   = (instr_i & `AMR_NOP_MASK) == `AMR_NOP_PAT;
    assign is_reti_o  = instr_i == `AMR_RETI_PAT;
    assign is_optld_o = instr_i == `AMR_OPTLD_PAT;

endmodule

`default_nettype wire

// ===== amr_decode.v
// decode and execute for literal load, store, nop, irq return, option load
`default_nettype none
`include "amr_consts.vh"

module amr_decode #(
    parameter OPT_ADDR = 7'h01,  // address of option register in file space
    parameter IRQ_ADDR = 7'h0b   // address of irq control register
) (
    input  wire        mclk_i,
    input  wire        rst_b_i,
    input  wire        instr_valid_i,   // fetched word is ready to execute
    input  wire [13:0] instr_i,
    input  wire [12:0] stack_top_entry_i, // current top of return stack
    input  wire [7:0]  irq_control_register_i, // current irq control value
    output reg  [7:0]  acc_o,           // working accumulator
    output reg         file_we_o,       // one-cycle register write strobe
    output reg  [6:0]  file_addr_o,
    output reg  [7:0]  file_wdata_o,
    output reg  [7:0]  option_o,        // option register contents
    output reg         stack_pop_o,     // one-cycle pop strobe
    output reg         pc_load_o,       // one-cycle program counter load
    output reg  [12:0] pc_value_o,
    output reg         irq_ctl_we_o,    // write of irq control register
    output reg  [7:0]  irq_ctl_wdata_o,
    output reg         busy_o,          // second cycle of a two-cycle op
    output reg         unknown_o        // word not of this group
);

    ////////////////////////////////////////////////////////////////////
    // pattern match
    wire is_ldlit;
    wire is_store;
    wire is_nop;
    wire is_reti;
    wire is_optld;

    amr_match u_match (
        .instr_i    (instr_i),
        .is_ldlit_o (is_ldlit),
        .is_store_o (is_store),
        .is_nop_o   (is_nop),
        .is_reti_o  (is_reti),
        .is_optld_o (is_optld)
    );

    ////////////////////////////////////////////////////////////////////
    // sequencer: idle, or flushing the second cycle of a return
    // a return owns two cycles: in the second the prefetched word is
    // stale and must not execute, so the sequencer parks for one edge
    localparam ST_RUN   = 1'b0;
    localparam ST_FLUSH = 1'b1;

    // set mask for the global enable bit in the irq control word
    localparam [7:0] GIE_MASK = 8'h01 << `AMR_GIE_BIT;

    reg        state_r;
    reg        state_nxt;
    wire       take;
    wire [6:0] fadr;

    // a word is executed only while the sequencer is free
    assign take = instr_valid_i && (state_r == ST_RUN);
    // register address field of a store word
    assign fadr = instr_i[`AMR_FW-1:0];

    ////////////////////////////////////////////////////////////////////
    // qualified operation strobes
    wire do_ldlit;
    wire do_store;
    wire do_reti;
    wire do_optld;
    wire do_other;
    wire hit_opt;
    wire hit_irq;

    // the group's encodings are disjoint, so at most one is high
    assign do_ldlit = take && is_ldlit;
    assign do_store = take && is_store;
    assign do_reti  = take && is_reti;
    assign do_optld = take && is_optld;
    // nop and foreign words change nothing; foreign ones are flagged
    assign do_other = take && !is_ldlit && !is_store && !is_reti
                      && !is_optld && !is_nop;

    // store targets that shadow a register held in this block
    assign hit_opt = (fadr == OPT_ADDR);
    assign hit_irq = (fadr == IRQ_ADDR);

    ////////////////////////////////////////////////////////////////////
    // sequencer next state
    // a fetch arriving during the flush cycle is discarded, as the
    // prefetched word after a return is stale
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (do_reti) begin
                    state_nxt = ST_FLUSH;
                end
            end
            ST_FLUSH: begin
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // sequencer state register
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // next values; no status flag output exists, so no op touches flags
    // limitation: the option shadow only follows stores made here
    reg [7:0]  acc_nxt;
    reg [6:0]  file_addr_nxt;
    reg [7:0]  file_wdata_nxt;
    reg [7:0]  option_nxt;
    reg [12:0] pc_value_nxt;
    reg [7:0]  irq_ctl_wdata_nxt;

    // held values change only on the op that owns them
    always @* begin
        acc_nxt           = acc_o;
        file_addr_nxt     = file_addr_o;
        file_wdata_nxt    = file_wdata_o;
        option_nxt        = option_o;
        pc_value_nxt      = pc_value_o;
        irq_ctl_wdata_nxt = irq_ctl_wdata_o;
        if (do_ldlit) begin
            acc_nxt = instr_i[`AMR_DW-1:0];
        end
        if (do_store) begin
            file_addr_nxt  = fadr;
            file_wdata_nxt = acc_o;
            if (hit_opt) begin
                option_nxt = acc_o;
            end
            if (hit_irq) begin
                irq_ctl_wdata_nxt = acc_o;
            end
        end
        if (do_reti) begin
            pc_value_nxt      = stack_top_entry_i;
            irq_ctl_wdata_nxt = irq_control_register_i
                              | GIE_MASK;
        end
        if (do_optld) begin
            option_nxt = acc_o;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // one-cycle strobes for the neighbouring units
    wire file_we_nxt;
    wire stack_pop_nxt;
    wire pc_load_nxt;
    wire irq_ctl_we_nxt;
    wire busy_nxt;
    wire unknown_nxt;

    assign file_we_nxt    = do_store;
    assign stack_pop_nxt  = do_reti;
    assign pc_load_nxt    = do_reti;
    // a store by address reaches the irq control register too
    assign irq_ctl_we_nxt = do_reti || (do_store && hit_irq);
    assign busy_nxt       = do_reti;
    assign unknown_nxt    = do_other;

    ////////////////////////////////////////////////////////////////////
    // strobe registers; recomputed every edge so each pulse lasts one
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            file_we_o    <= 1'b0;
            stack_pop_o  <= 1'b0;
            pc_load_o    <= 1'b0;
            irq_ctl_we_o <= 1'b0;
            busy_o       <= 1'b0;
            unknown_o    <= 1'b0;
        end else begin
            file_we_o    <= file_we_nxt;
            stack_pop_o  <= stack_pop_nxt;
            pc_load_o    <= pc_load_nxt;
            irq_ctl_we_o <= irq_ctl_we_nxt;
            busy_o       <= busy_nxt;
            unknown_o    <= unknown_nxt;
        end
    end

    // held registers; reset values match an idle core
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            acc_o           <= `AMR_ACC_RST;
            file_addr_o     <= 7'h00;
            file_wdata_o    <= 8'h00;
            option_o        <= `AMR_OPT_RST;
            pc_value_o      <= 13'h0000;
            irq_ctl_wdata_o <= 8'h00;
        end else begin
            acc_o           <= acc_nxt;
            file_addr_o     <= file_addr_nxt;
            file_wdata_o    <= file_wdata_nxt;
            option_o        <= option_nxt;
            pc_value_o      <= pc_value_nxt;
            irq_ctl_wdata_o <= irq_ctl_wdata_nxt;
        end
    end

endmodule

`default_nettype wire

// ===== amr_decode_checker.sv
// port-level assertions for the decoder group
`default_nettype none
module amr_decode_checker #(parameter OPT_ADDR = 7'h01) (
    input wire logic        mclk_i,
    input wire logic        rst_b_i,
    input wire logic        instr_valid_i,
    input wire logic [13:0] instr_i,
    input wire logic [7:0]  acc_o,
    input wire logic        file_we_o,
    input wire logic [7:0]  option_o,
    input wire logic        stack_pop_o,
    input wire logic        pc_load_o,
    input wire logic [7:0]  irq_ctl_wdata_o,
    input wire logic        busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    // the flush cycle after a return takes no word
    wire tk = instr_valid_i && !busy_o;
    wire rt = tk && instr_i == 14'h0009;
    property p_ld; tk && instr_i[13:10] == 4'hc
        |=> acc_o == $past(instr_i[7:0]); endproperty
    a_ld: assert property (p_ld) else $error("bad load");
    property p_st; tk && instr_i[13:7] == 7'h01 |=> file_we_o; endproperty
    a_st: assert property (p_st) else $error("bad store");
    property p_op; tk && instr_i == {7'h01, OPT_ADDR[6:0]}
        |=> option_o == $past(acc_o); endproperty
    a_op: assert property (p_op) else $error("bad opt");
    property p_ol; tk && instr_i == 14'h0062
        |=> option_o == $past(acc_o); endproperty
    a_ol: assert property (p_ol) else $error("bad optld");
    property p_rp; rt |=> stack_pop_o && pc_load_o; endproperty
    a_rp: assert property (p_rp) else $error("bad pop");
    property p_ge; rt |=> irq_ctl_wdata_o[7]; endproperty
    a_ge: assert property (p_ge) else $error("bad enable");
    property p_bz; rt |=> busy_o ##1 !busy_o; endproperty
    a_bz: assert property (p_bz) else $error("bad busy");
    property p_np; tk && (instr_i & 14'h3f9f) == 14'h0000
        |=> $stable(acc_o) && !file_we_o && !stack_pop_o; endproperty
    a_np: assert property (p_np) else $error("bad nop");
endmodule
bind amr_decode amr_decode_checker #(.OPT_ADDR(OPT_ADDR)) u_chk (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .acc_o(acc_o), .file_we_o(file_we_o),
    .option_o(option_o), .stack_pop_o(stack_pop_o), .pc_load_o(pc_load_o),
    .irq_ctl_wdata_o(irq_ctl_wdata_o), .busy_o(busy_o));
`default_nettype wire

// ===== amr_decode_tb.sv
// self-checking bench for the decoder group
`default_nettype none
module amr_decode_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk_i = 0, rst_b_i = 0, vld = 0;
    logic [13:0] ins = 14'h0000;
    logic [12:0] top = 13'h1abc;
    logic [7:0]  ctl = 8'h12;
    wire  [7:0]  acc, opt, wd, cw;
    wire  [12:0] pc;
    wire  [6:0]  ad;
    wire         we, pop, pcl, cwe, busy, unk;
    int          fail_count = 0, total_checks = 0;
    amr_decode u_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .instr_valid_i(vld), .instr_i(ins), .stack_top_entry_i(top),
        .irq_control_register_i(ctl), .acc_o(acc), .file_we_o(we),
        .file_addr_o(ad), .file_wdata_o(wd), .option_o(opt),
        .stack_pop_o(pop), .pc_load_o(pcl), .pc_value_o(pc),
        .irq_ctl_we_o(cwe), .irq_ctl_wdata_o(cw), .busy_o(busy),
        .unknown_o(unk));
    task automatic chk(input logic ok);
        total_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("[ERR] %0t mismatch", $time);
        end
    endtask
    // word goes out on the falling edge, outputs read just after rising
    task automatic op(input logic [13:0] w);
        @(negedge mclk_i);
        ins = w;
        vld = 1;
        @(posedge mclk_i);
        #1;
    endtask
    task automatic t_lit;
        op(14'h3055); chk(acc === 8'h55);
        op(14'h33aa); chk(acc === 8'haa);
    endtask
    task automatic t_st;
        op(14'h00ff);
        chk(we === 1 && ad === 7'h7f && wd === 8'haa);
        op(14'h0060);
        chk(we === 0 && acc === 8'haa && unk === 0);
    endtask
    task automatic t_opt;
        op(14'h0081); chk(opt === 8'haa);
        op(14'h304f);
        op(14'h0062); chk(opt === 8'h4f);
    endtask
    // return followed at once by a word that must be dropped
    task automatic t_ret;
        op(14'h0009);
        chk(pop === 1 && pcl === 1 && pc === 13'h1abc);
        chk(cwe === 1 && cw === 8'h92);
        chk(busy === 1);
        op(14'h3011);
        chk(busy === 0 && acc === 8'h4f && pop === 0);
        op(14'h3022); chk(acc === 8'h22);
        // second return with other stack and control values
        @(negedge mclk_i);
        top = 13'h0555;
        ctl = 8'h01;
        op(14'h0009); chk(pc === 13'h0555 && cw === 8'h81);
        op(14'h0000); chk(busy === 0 && pcl === 0);
    endtask
    // foreign word, then a store to the irq control address
    task automatic t_misc;
        op(14'h0008); chk(unk === 1 && we === 0 && pop === 0);
        op(14'h008b); chk(we === 1 && cwe === 1 && cw === 8'h22);
    endtask
    // reset in mid-run, then a first word on the second rising edge after release
    task automatic t_rst;
        @(negedge mclk_i);
        vld = 0;
        rst_b_i = 0;
        @(negedge mclk_i);
        rst_b_i = 1;
        chk(acc === 8'h00 && opt === 8'hff && busy === 0);
        op(14'h3077); chk(acc === 8'h77);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial forever #20 mclk_i = ~mclk_i;
    initial begin
        repeat (6) @(posedge mclk_i);
        @(negedge mclk_i);
        rst_b_i = 1;
        chk(acc === 8'h00 && opt === 8'hff);
        t_lit;
        t_st;
        t_opt;
        t_ret;
        t_misc;
        t_rst;
        tally_and_finish;
    end
endmodule
`default_nettype wire
